// file: src/filtered_lfsr_shrink_keystream.sv
// Purpose: filtered shift-register keystream generator with decimation and rate buffer
// Assumes: key_in/iv_in stable in the load_strobe cycle; consumer takes every ks_valid cycle
// Notes: a starved buffer simply skips the flag for that slot
`timescale 1ns/1ps
`default_nettype none
module filtered_lfsr_shrink_keystream (
    input wire logic ref_clk, // 100 MHz clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic load_strobe, // one-cycle pulse, take key and iv, start setup
    input wire logic [keystream_pkg::KEY_LEN-1:0] key_in, // secret key, bit i is key bit i
    input wire logic [keystream_pkg::IV_LEN-1:0] iv_in, // initialisation vector
    output logic init_busy, // high during the setup clocks
    output logic ks_valid, // keystream bit valid this cycle
    output logic ks_bit // keystream bit
);
    keystream_pkg::ctrl_e ctrl_reg;
    keystream_pkg::dec_e dec_reg;
    logic [keystream_pkg::LFSR_LEN-1:0] lfsr_reg;
    logic [keystream_pkg::LFSR_LEN-1:0] fill;
    logic [keystream_pkg::FILT_INPUTS-1:0] taps;
    logic [9:0] init_cnt_reg;
    logic lin_fb;
    logic y;
    logic ref_reg;
    logic cand_reg;
    logic emit;
    logic emit_bit;
    logic [keystream_pkg::BUF_DEPTH-1:0] buf_reg;
    logic [4:0] wr_ptr_reg;
    logic [4:0] rd_ptr_reg;
    logic [5:0] count_reg;
    logic [1:0] rate_reg;
    logic started_reg;
    logic push;
    logic pop;
    logic running;

    assign running = (ctrl_reg == keystream_pkg::ST_RUN);

    // per-stage initial fill
    genvar gi;
    generate
        for (gi = 0; gi < keystream_pkg::LFSR_LEN; gi++) begin : g_fill
            if (gi < keystream_pkg::SEG_KEY_IV) begin : g_key
                assign fill[gi] = key_in[gi];
            end else if (gi < keystream_pkg::SEG_KEY_IV4) begin : g_kiv
                assign fill[gi] = key_in[gi-keystream_pkg::OFS_KEY] ^ iv_in[gi-keystream_pkg::OFS_IV_A];
            end else if (gi < keystream_pkg::SEG_IV2) begin : g_kiv4
                assign fill[gi] = key_in[gi-keystream_pkg::OFS_KEY] ^ iv_in[gi-keystream_pkg::OFS_IV_B]
                    ^ iv_in[gi-keystream_pkg::OFS_IV_C] ^ iv_in[gi-keystream_pkg::OFS_IV_D]
                    ^ iv_in[gi-keystream_pkg::OFS_IV_E];
            end else begin : g_iv2
                assign fill[gi] = ~(iv_in[gi-keystream_pkg::OFS_IV_F] ^ iv_in[gi-keystream_pkg::OFS_IV_C]);
            end
        end
        for (gi = 0; gi < keystream_pkg::FILT_INPUTS; gi++) begin : g_taps
            assign taps[gi] = lfsr_reg[keystream_pkg::FILT_TAPS[gi]];
        end
    endgenerate

    always_comb begin
        lin_fb = 1'b0;
        for (int k = 0; k < keystream_pkg::FB_TAP_CNT; k++) begin
            lin_fb = lin_fb ^ lfsr_reg[keystream_pkg::FB_TAPS[k]];
        end
    end

    resilient_filter u_filter (
        .taps(taps),
        .y(y)
    );

    // control: idle, setup, keystream
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl_reg <= keystream_pkg::ST_IDLE;
            init_cnt_reg <= keystream_pkg::INIT_CNT_ZERO;
        end else if (load_strobe) begin
            ctrl_reg <= keystream_pkg::ST_INIT;
            init_cnt_reg <= keystream_pkg::INIT_CNT_ZERO;
        end else if (ctrl_reg == keystream_pkg::ST_INIT) begin
            init_cnt_reg <= init_cnt_reg + 10'h001;
            if (init_cnt_reg == keystream_pkg::INIT_CNT_LAST) begin
                ctrl_reg <= keystream_pkg::ST_RUN;
            end
        end
    end

    // shift register
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            lfsr_reg <= '0;
        end else if (load_strobe) begin
            lfsr_reg <= fill;
        end else if (ctrl_reg == keystream_pkg::ST_INIT) begin
            lfsr_reg <= {lin_fb ^ y, lfsr_reg[keystream_pkg::LFSR_LEN-1:1]};
        end else if (running) begin
            lfsr_reg <= {lin_fb, lfsr_reg[keystream_pkg::LFSR_LEN-1:1]};
        end
    end

    // decimator, one filtered bit per clock
    always_comb begin
        emit = 1'b0;
        emit_bit = cand_reg;
        if (running) begin
            if (dec_reg == keystream_pkg::DEC_CAND && y == ref_reg) begin
                emit = 1'b1;
                emit_bit = y;
            end else if (dec_reg == keystream_pkg::DEC_SCAN && y == ref_reg) begin
                emit = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn || !running) begin
            dec_reg <= keystream_pkg::DEC_REF;
            ref_reg <= 1'b0;
            cand_reg <= 1'b0;
        end else begin
            unique case (dec_reg)
                keystream_pkg::DEC_REF: begin
                    ref_reg <= y;
                    dec_reg <= keystream_pkg::DEC_CAND;
                end
                keystream_pkg::DEC_CAND: begin
                    cand_reg <= y;
                    dec_reg <= emit ? keystream_pkg::DEC_REF : keystream_pkg::DEC_SCAN;
                end
                keystream_pkg::DEC_SCAN: begin
                    if (emit) begin
                        dec_reg <= keystream_pkg::DEC_REF;
                    end
                end
            endcase
        end
    end

    // rate buffer; a full buffer drops new bits even if a bit leaves this cycle
    assign push = emit && (count_reg != keystream_pkg::BUF_FULL);
    // gated by running: after a reload the stale started flag must not pop a bit into setup
    assign pop = running && started_reg && (rate_reg == keystream_pkg::RATE_LAST)
        && (count_reg != keystream_pkg::BUF_EMPTY);

    always_ff @(posedge ref_clk) begin
        if (!rstn || !running) begin
            rate_reg <= keystream_pkg::RATE_ZERO;
            started_reg <= 1'b0;
            count_reg <= keystream_pkg::BUF_EMPTY;
            wr_ptr_reg <= keystream_pkg::PTR_ZERO;
            rd_ptr_reg <= keystream_pkg::PTR_ZERO;
        end else begin
            rate_reg <= rate_reg + 2'h1;
            if (count_reg == keystream_pkg::BUF_FULL) begin
                started_reg <= 1'b1;
            end
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 5'h01;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 5'h01;
            end
            count_reg <= count_reg + {5'h00, push} - {5'h00, pop};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            buf_reg <= '0;
        end else if (push) begin
            buf_reg[wr_ptr_reg] <= emit_bit;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ks_valid <= 1'b0;
            ks_bit <= 1'b0;
            init_busy <= 1'b0;
        end else begin
            ks_valid <= pop && !load_strobe;
            ks_bit <= buf_reg[rd_ptr_reg];
            init_busy <= load_strobe || (ctrl_reg == keystream_pkg::ST_INIT
                && init_cnt_reg != keystream_pkg::INIT_CNT_LAST);
        end
    end

    // setup length helper for the checks; a reload restarts the count
    logic [9:0] setup_len_reg;

    always_ff @(posedge ref_clk) begin
        if (!rstn || load_strobe) begin
            setup_len_reg <= keystream_pkg::INIT_CNT_ZERO;
        end else if (init_busy) begin
            setup_len_reg <= setup_len_reg + 10'h001;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_load_fill: assert property (load_strobe |=> lfsr_reg[0] == $past(key_in[0])
        && lfsr_reg[191] == ~($past(iv_in[31]) ^ $past(iv_in[63])))
        else $error("register fill wrong after load");
    a_init_enter: assert property (load_strobe |=> init_busy && ctrl_reg == keystream_pkg::ST_INIT)
        else $error("load did not start setup");
    a_init_len: assert property ($fell(init_busy)
        |-> setup_len_reg == 10'(keystream_pkg::INIT_CLOCKS))
        else $error("setup length not 768 clocks");
    a_init_max: assert property (init_busy
        |-> setup_len_reg < 10'(keystream_pkg::INIT_CLOCKS))
        else $error("setup longer than 768 clocks");
    a_init_fb: assert property (ctrl_reg == keystream_pkg::ST_INIT && !load_strobe
        |=> lfsr_reg[191] == $past(lin_fb ^ y))
        else $error("setup feedback wrong");
    a_run_shift: assert property (running && !load_strobe |=> lfsr_reg[191] == $past(lin_fb)
        && lfsr_reg[190:0] == $past(lfsr_reg[191:1]))
        else $error("keystream shift wrong");
    a_init_silent: assert property (init_busy |-> !ks_valid)
        else $error("output during setup");
    a_dec_idle: assert property (!running |=> dec_reg == keystream_pkg::DEC_REF && count_reg == 6'h00)
        else $error("decimator active outside keystream mode");
    a_no_early: assert property (ks_valid |-> started_reg)
        else $error("keystream before buffer full");
    a_rate_gap: assert property (ks_valid |=> !ks_valid [*3])
        else $error("more than one bit per four shifts");
    a_full_drop: assert property (emit && count_reg == keystream_pkg::BUF_FULL && !pop && running
        && !load_strobe |=> count_reg == keystream_pkg::BUF_FULL && wr_ptr_reg == $past(wr_ptr_reg))
        else $error("bit enqueued into full buffer");
    a_cand_emit: assert property (running && !load_strobe && dec_reg == keystream_pkg::DEC_CAND
        && y == ref_reg |-> push || count_reg == keystream_pkg::BUF_FULL)
        else $error("candidate not emitted");

    c_init_done: cover property ($fell(init_busy));
    c_buf_full: cover property (running && count_reg == keystream_pkg::BUF_FULL);
    c_drop: cover property (emit && count_reg == keystream_pkg::BUF_FULL);
    c_ks_out: cover property (ks_valid ##4 ks_valid);
endmodule : filtered_lfsr_shrink_keystream
`default_nettype wire

// file: src/keystream_pkg.sv
// Purpose: shared constants and types for the filtered-register keystream generator
// Assumes: one clock, synchronous active-low reset
// Notes: tap tables are register stage indices, stage 0 being the oldest bit
package keystream_pkg;
    localparam int LFSR_LEN = 192;
    localparam int KEY_LEN = 80;
    localparam int IV_LEN = 64;
    localparam int FILT_INPUTS = 14;
    localparam int SYM_INPUTS = 13;
    localparam int FB_TAP_CNT = 14;
    // linear feedback: exponents of the polynomial below the top term
    localparam int FB_TAPS [FB_TAP_CNT] = '{0, 5, 16, 17, 46, 77, 94, 131, 132, 155, 156, 169, 188, 189};
    // filter inputs; last one is the linear term, taken at stage 1
    localparam int FILT_TAPS [FILT_INPUTS] = '{191, 186, 178, 172, 162, 144, 111, 104, 65, 54, 45, 28, 13, 1};
    // initial fill segment bounds and IV offsets
    localparam int SEG_KEY_IV = 80;
    localparam int SEG_KEY_IV4 = 144;
    localparam int SEG_IV2 = 160;
    localparam int OFS_KEY = 80;
    localparam int OFS_IV_A = 80;
    localparam int OFS_IV_B = 144;
    localparam int OFS_IV_C = 128;
    localparam int OFS_IV_D = 112;
    localparam int OFS_IV_E = 96;
    localparam int OFS_IV_F = 160;
    localparam int INIT_CLOCKS = 768;
    localparam logic [9:0] INIT_CNT_ZERO = 10'h000;
    localparam logic [9:0] INIT_CNT_LAST = 10'(INIT_CLOCKS - 1);
    localparam int BUF_DEPTH = 32;
    localparam logic [5:0] BUF_FULL = 6'(BUF_DEPTH);
    localparam logic [5:0] BUF_EMPTY = 6'h00;
    localparam logic [4:0] PTR_ZERO = 5'h00;
    // last count of the rate counter; one keystream bit per four register shifts
    localparam logic [1:0] RATE_LAST = 2'h3;
    localparam logic [1:0] RATE_ZERO = 2'h0;

    typedef enum logic [1:0] {ST_IDLE, ST_INIT, ST_RUN} ctrl_e;
    typedef enum logic [1:0] {DEC_REF, DEC_CAND, DEC_SCAN} dec_e;
endpackage : keystream_pkg

// file: src/resilient_filter.sv
// Purpose: 14-input filter, quadratic symmetric function of 13 inputs xor a linear input
// Assumes: purely combinational
// Notes: bit 13 of taps is the linear input
`timescale 1ns/1ps
`default_nettype none
module resilient_filter (
    input wire logic [keystream_pkg::FILT_INPUTS-1:0] taps, // tapped register bits
    output logic y // filter output
);
    logic quad;
    logic lin;

    always_comb begin
        quad = 1'b0;
        lin = 1'b0;
        for (int i = 0; i < keystream_pkg::SYM_INPUTS; i++) begin
            lin = lin ^ taps[i];
            for (int j = i + 1; j < keystream_pkg::SYM_INPUTS; j++) begin
                quad = quad ^ (taps[i] & taps[j]);
            end
        end
        y = quad ^ lin ^ taps[keystream_pkg::SYM_INPUTS];
    end
endmodule : resilient_filter
`default_nettype wire

// file: verification/keystream_host.sv
// Purpose: host partner, presents key and iv with a one-cycle load pulse
// Assumes: go is a request from the bench, taken at the rising edge
// Notes: key and iv lines toggle outside the load cycle so stale sampling shows
`timescale 1ns/1ps
`default_nettype none
module keystream_host (
    input wire logic ref_clk, // clock
    input wire logic rstn, // sync reset, active low
    input wire logic go, // load request
    input wire logic [keystream_pkg::KEY_LEN-1:0] key_q, // key to send
    input wire logic [keystream_pkg::IV_LEN-1:0] iv_q, // iv to send
    output logic load_strobe, // load pulse
    output logic [keystream_pkg::KEY_LEN-1:0] key_in, // key lines
    output logic [keystream_pkg::IV_LEN-1:0] iv_in // iv lines
);
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            load_strobe <= 1'b0;
            key_in <= '0;
            iv_in <= '0;
        end else begin
            load_strobe <= go;
            key_in <= go ? key_q : ~key_in;
            iv_in <= go ? iv_q : ~iv_in;
        end
    end
endmodule : keystream_host
`default_nettype wire

// file: verification/filtered_lfsr_shrink_keystream_tb.sv
// Purpose: self-checking bench with an edge-by-edge model of the generator
// Assumes: a buffer pop at one edge shows as ks_valid before the next edge
// Notes: pop moments come from ks_valid; bits, counts and drops are the model's own
`timescale 1ns/1ps
`default_nettype none
module filtered_lfsr_shrink_keystream_tb;
    localparam int ftap[14] = '{191, 186, 178, 172, 162, 144, 111, 104, 65, 54, 45, 28, 13, 1};
    localparam int fbtap[14] = '{0, 5, 16, 17, 46, 77, 94, 131, 132, 155, 156, 169, 188, 189};
    logic ref_clk, rstn, go, load_strobe, init_busy, ks_valid, ks_bit, y, e, zc, started;
    logic [79:0] key_q, key_in;
    logic [63:0] iv_q, iv_in;
    logic [191:0] st;
    logic [31:0] seed;
    logic q[$];
    int errors, num_checks, cnt, busy_n, gap, mode, dstate, nrx;

    keystream_host host_u (.ref_clk(ref_clk), .rstn(rstn), .go(go), .key_q(key_q), .iv_q(iv_q),
        .load_strobe(load_strobe), .key_in(key_in), .iv_in(iv_in));
    filtered_lfsr_shrink_keystream dut_u (.ref_clk(ref_clk), .rstn(rstn), .load_strobe(load_strobe),
        .key_in(key_in), .iv_in(iv_in), .init_busy(init_busy), .ks_valid(ks_valid), .ks_bit(ks_bit));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic filt(input logic [191:0] x);
        int w;
        w = 0;
        for (int k = 0; k < 13; k++) w += int'(x[ftap[k]]);
        return 1'((w * (w - 1) / 2 + w) % 2) ^ x[ftap[13]];
    endfunction : filt

    function automatic logic lin(input logic [191:0] x);
        logic r;
        r = 1'b0;
        foreach (fbtap[k]) r ^= x[fbtap[k]];
        return r;
    endfunction : lin

    function automatic logic [191:0] fill(input logic [79:0] k, input logic [63:0] v);
        logic [191:0] x;
        for (int i = 0; i < 192; i++) begin
            if (i < 80) x[i] = k[i];
            else if (i < 144) x[i] = k[i-80] ^ v[i-80];
            else if (i < 160) x[i] = k[i-80] ^ v[i-144] ^ v[i-128] ^ v[i-112] ^ v[i-96];
            else x[i] = v[i-160] ^ v[i-128] ^ 1'b1;
        end
        return x;
    endfunction : fill

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    // reference model, one step per rising edge on pre-edge values
    always @(posedge ref_clk) begin
        y = filt(st);
        if (!rstn) begin
            mode = 0;
            q.delete();
            started = 1'b0;
            busy_n = 0;
        end else begin
            if (init_busy) busy_n++;
            else if (busy_n > 0) check(busy_n, 768);
            if (!init_busy) busy_n = 0;
            if (ks_valid === 1'b1) begin
                check({started, mode == 2}, 2'h3);
                check(ks_bit, q.size() ? q[0] : ~ks_bit);
                if (q.size() > 0) void'(q.pop_front());
                if (nrx > 0) check(gap, 4);
                nrx++;
                gap = 0;
            end
            gap++;
            if (mode == 1) begin
                st = {lin(st) ^ y, st[191:1]};
                cnt++;
                mode = (cnt == 768) ? 2 : 1;
            end else if (mode == 2) begin
                if (dstate == 0) begin
                    e = y;
                    dstate = 1;
                end else begin
                    if (dstate == 1) zc = y;
                    dstate = (y == e) ? 0 : 2;
                    if (y == e && q.size() < 32) q.push_back(zc);
                end
                if (q.size() == 32) started = 1'b1;
                st = {lin(st), st[191:1]};
            end
            if (load_strobe) begin
                st = fill(key_in, iv_in);
                mode = 1;
                {cnt, dstate, nrx, busy_n} = '0;
                q.delete();
                started = 1'b0;
            end
        end
    end

    task automatic run(input logic [79:0] k, input logic [63:0] v, input int nbits);
        @(posedge ref_clk);
        key_q <= k;
        iv_q <= v;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (2) @(posedge ref_clk);
        for (int c = 0; c < 3000 && nrx < nbits; c++) @(posedge ref_clk);
        check(nrx >= nbits, 1);
        $display("test done: %0d keystream bits", nrx);
    endtask : run

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        #400000;
        errors++;
        final_report();
    end

    initial begin
        {rstn, go, key_q, iv_q, errors, num_checks, gap, nrx, dstate} = '0;
        seed = 32'h005D8732;
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        check({init_busy, ks_valid}, 2'h0);
        run('0, '0, 40);
        run('1, '1, 40);
        run(80'({rnd(), rnd(), rnd()}), {rnd(), rnd()}, 0); // reload during setup next
        for (int t = 0; t < 5; t++) run(80'({rnd(), rnd(), rnd()}), {rnd(), rnd()}, (t % 2) ? 3 : 60);
        final_report();
    end
endmodule : filtered_lfsr_shrink_keystream_tb
`default_nettype wire
